// [verilog/bulk_ep_pkg.sv]
// shared constants for the bulk endpoint control block
package bulk_ep_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_COUNT  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IN_MTU = 8'h0c;
  localparam logic [7:0] OFF_OUT_MTU = 8'h10;
  localparam logic [7:0] OFF_IN_POST = 8'h14;
  localparam logic [7:0] OFF_OUT_POST = 8'h18;
  localparam logic [7:0] OFF_DEPTH  = 8'h1c;
  localparam logic [7:0] OFF_CN     = 8'h20;
  // control bits
  localparam int C_CONT  = 0;
  localparam int C_BLOCK = 1;
  localparam int C_STALL = 2;
  localparam int C_HALT  = 3;
  localparam int C_CLEAR = 4;
  localparam int C_FLUSH_IN  = 5;
  localparam int C_FLUSH_OUT = 6;
  // status bits (write 1 to clear)
  localparam int S_DONE  = 0;
  localparam int S_OVER  = 1;
  localparam int S_LEFT  = 2;
  localparam int S_ACK   = 3;
  localparam int S_NAK   = 4;
  localparam int S_ZLP   = 5;
  localparam int S_FDONE_IN  = 6;
  localparam int S_FDONE_OUT = 7;
  localparam int S_W = 8;
  // post word: bit 31 = last, bits 15:0 = length
  localparam int P_LAST = 31;
  localparam int LEN_W  = 16;
  localparam logic [15:0] MTU_RESET = 16'h0200;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam int CLEAR_CYCLES = 4;
  // handshake answers
  typedef enum logic [1:0] {
    HS_NAK   = 2'b00,
    HS_ACK   = 2'b01,
    HS_STALL = 2'b11
  } handshake_e;
endpackage

// [verilog/work_queue.sv]
// four-deep work queue of posted buffers for one direction
module work_queue
  import bulk_ep_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clear,
  input  wire logic             push,
  input  wire logic             push_last,
  input  wire logic [LEN_W-1:0] push_len,
  input  wire logic             pop,
  input  wire logic             consume,
  input  wire logic [LEN_W-1:0] consume_len,
  output logic                  head_last,
  output logic [LEN_W-1:0]      head_len,
  output logic [LEN_W-1:0]      second_len,
  output logic [2:0]            count
);
  logic [LEN_W-1:0] len_q [DEPTH];
  logic             last_q [DEPTH];
  logic [1:0]       head;
  logic [1:0]       tail;

  assign head_len   = len_q[head];
  assign head_last  = last_q[head];
  assign second_len = len_q[head + 2'd1];

  // overposting wraps onto older entries; firmware keeps within DEPTH
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      head  <= 2'd0;
      tail  <= 2'd0;
      count <= 3'd0;
    end else begin
      if (push)
        tail <= tail + 2'd1;
      if (pop)
        head <= head + 2'd1;
      count <= count + {2'b00, push} - {2'b00, pop};
    end
  end

  always_ff @(posedge aclk) begin
    if (push) begin
      len_q[tail]  <= push_len;
      last_q[tail] <= push_last;
    end
    if (consume && !pop)
      len_q[head] <= head_len - consume_len;
  end
endmodule

// [verilog/usb_bulk_endpoint_control.sv]
// bulk endpoint control: modes, block count, queues, stall, flush
// Contract
// - both mode enables low means endpoint disabled.
// - ack data request when a buffer is available, otherwise nak.
// - subtract packet size from count only after good bus status.
// - count zero clears block enable, sets done; underflow sets overflow.
// - in-path last buffer ends block; nonzero count raises leftover error.
// - out-path short packet ends block; nonzero count raises leftover error.
// - out-path zero-length packet ends block, sets zlp and leftover.
// - after each good packet update head entry length, post notice.
// - each direction queues up to four posted buffers.
// - out buffer available if >= mtu, last, or another queued.
// - in single or last head: prefetch, one mtu per in.
// - in two buffers no last: prefetch across two, fill one mtu.
// - depth field reports entry count, independent of notices.
// - one-shot stall answers next access, clears; copy stalls until clear.
// - sticky halt stalls every access while set.
// - ack, nak, zlp flags set on event, cleared by firmware or reset.
// - endpoint clear request discards state, self clears when done.
// - flush waits for packet, no entries means nothing (here it still clears the flush bit and sets done).
// - flush retires entries with zero-length notices, then sets done.
module usb_bulk_endpoint_control
  import bulk_ep_pkg::*;
#(
  parameter int PREFETCH = 64
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              token_valid,
  input  wire logic              token_in,
  input  wire logic              clear_halt,
  output logic                   hs_valid,
  output handshake_e             hs_code,
  input  wire logic              pkt_done,
  input  wire logic              pkt_good,
  input  wire logic              pkt_in,
  input  wire logic [LEN_W-1:0]  pkt_len,
  output logic                   notice_valid,
  output logic                   notice_in,
  output logic [LEN_W-1:0]       notice_len,
  input  wire logic              notice_ready,
  output logic                   fetch_valid,
  output logic [LEN_W-1:0]       fetch_len,
  output logic                   busy
);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_XFER  = 2'b01,
    ST_FLUSH = 2'b11,
    ST_CLEAR = 2'b10
  } state_e;

  state_e           state;
  logic             continuous_enable;
  logic             block_transfer_enable;
  logic             stall_once;
  logic             stall_copy;
  logic             sticky_halt_bit;
  logic             endpoint_clear_request;
  logic             flush_in;
  logic             flush_out;
  logic [31:0]      transfer_count;
  logic [S_W-1:0]   status;
  logic [LEN_W-1:0] in_mtu;
  logic [LEN_W-1:0] out_mtu;
  logic [2:0]       clear_cnt;
  logic             cur_in;
  logic             aw_hold;
  logic             w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]      w_data;
  logic             wr_fire;
  logic             primed;

  // queue signals
  logic             in_last, out_last;
  logic [LEN_W-1:0] in_len, out_len, in_len2, out_len2;
  logic [2:0]       in_cnt, out_cnt;
  logic             in_push, out_push;
  logic             in_pop, out_pop;
  logic             in_use, out_use;
  logic [LEN_W-1:0] use_len;
  logic             q_clear;

  function automatic logic [LEN_W-1:0] min_len(input logic [LEN_W-1:0] a,
                                               input logic [LEN_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  wire enabled = continuous_enable | block_transfer_enable;
  wire in_avail  = (in_cnt != 3'd0);
  wire out_avail = (out_cnt != 3'd0) &&
                   (out_len >= out_mtu || out_last ||
                    out_cnt >= 3'd2);
  wire stalling  = stall_once | stall_copy | sticky_halt_bit;
  wire good_pkt  = pkt_done && pkt_good && state == ST_XFER;
  wire short_pkt = good_pkt && !pkt_in && pkt_len < out_mtu;
  wire [32:0] diff = {1'b0, transfer_count} - {17'd0, pkt_len};

  assign q_clear = !aresetn || state == ST_CLEAR;
  assign busy    = state != ST_IDLE;

  // register bus: write address and data taken in either order
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign wr_fire       = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr <= OFF_OUT_POST) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  wire wr_ctrl  = wr_fire && aw_addr == OFF_CTRL && s_axi_wstrb[0];
  wire wr_count = wr_fire && aw_addr == OFF_COUNT;
  wire wr_stat  = wr_fire && aw_addr == OFF_STATUS && s_axi_wstrb[0];

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFF_CTRL: s_axi_rdata <= {25'd0, flush_out, flush_in,
                                  endpoint_clear_request, sticky_halt_bit,
                                  stall_once, block_transfer_enable,
                                  continuous_enable};
        OFF_COUNT:   s_axi_rdata <= transfer_count;
        OFF_STATUS:  s_axi_rdata <= {24'd0, status};
        OFF_IN_MTU:  s_axi_rdata <= {16'd0, in_mtu};
        OFF_OUT_MTU: s_axi_rdata <= {16'd0, out_mtu};
        OFF_DEPTH:   s_axi_rdata <= {13'd0, out_cnt, 13'd0, in_cnt};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // posting: a write to a post offset pushes one entry
  assign in_push  = wr_fire && aw_addr == OFF_IN_POST;
  assign out_push = wr_fire && aw_addr == OFF_OUT_POST;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_mtu  <= MTU_RESET;
      out_mtu <= MTU_RESET;
    end else if (wr_fire && aw_addr == OFF_IN_MTU)
      in_mtu <= w_data[LEN_W-1:0];
    else if (wr_fire && aw_addr == OFF_OUT_MTU)
      out_mtu <= w_data[LEN_W-1:0];
  end

  // mode, stall and request bits
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_CLEAR) begin
      continuous_enable     <= 1'b0;
      block_transfer_enable <= 1'b0;
      stall_once            <= 1'b0;
      stall_copy            <= 1'b0;
      sticky_halt_bit       <= 1'b0;
      flush_in              <= 1'b0;
      flush_out             <= 1'b0;
      endpoint_clear_request <= !aresetn ? 1'b0 : (clear_cnt != 3'd0);
    end else begin
      if (wr_ctrl) begin
        continuous_enable     <= w_data[C_CONT];
        block_transfer_enable <= w_data[C_BLOCK];
        stall_once            <= w_data[C_STALL];
        sticky_halt_bit       <= w_data[C_HALT];
        endpoint_clear_request <= w_data[C_CLEAR];
        flush_in  <= flush_in | w_data[C_FLUSH_IN];
        flush_out <= flush_out | w_data[C_FLUSH_OUT];
      end
      if (good_pkt && block_transfer_enable &&
          (diff[32] || diff[31:0] == 32'd0 || short_pkt ||
           (pkt_in && in_last && pkt_len >= in_len)))
        block_transfer_enable <= 1'b0;
      if (token_valid && stall_once) begin
        stall_once <= 1'b0;
        stall_copy <= 1'b1;
      end
      if (clear_halt)
        stall_copy <= 1'b0;
      if (state == ST_FLUSH && in_cnt == 3'd0 && !notice_valid)
        flush_in <= 1'b0;
      if (state == ST_FLUSH && out_cnt == 3'd0 && !notice_valid)
        flush_out <= 1'b0;
    end
  end

  // transfer count
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_CLEAR)
      transfer_count <= '0;
    else if (wr_count)
      transfer_count <= w_data;
    else if (good_pkt && block_transfer_enable)
      transfer_count <= diff[32] ? 32'd0 : diff[31:0];
  end

  // handshake answer
  always_comb begin
    hs_valid = token_valid;
    if (stalling)
      hs_code = HS_STALL;
    else if (enabled && state == ST_IDLE &&
             (token_in ? in_avail : out_avail))
      hs_code = HS_ACK;
    else
      hs_code = HS_NAK;
  end

  // sticky flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_CLEAR)
      status <= '0;
    else begin
      logic [S_W-1:0] set_v;
      set_v = '0;
      set_v[S_ACK] = token_valid && hs_code == HS_ACK;
      set_v[S_NAK] = token_valid && hs_code == HS_NAK;
      if (good_pkt && block_transfer_enable) begin
        set_v[S_DONE] = diff[31:0] == 32'd0 && !diff[32];
        set_v[S_OVER] = diff[32];
        set_v[S_LEFT] = diff[31:0] != 32'd0 && !diff[32] &&
                        (short_pkt || (pkt_in && in_last &&
                                       pkt_len >= in_len));
        if (!pkt_in && pkt_len == '0) begin
          set_v[S_ZLP]  = 1'b1;
          set_v[S_LEFT] = 1'b1;
        end
      end else if (good_pkt && !pkt_in && pkt_len == '0)
        set_v[S_ZLP] = 1'b1;
      if (good_pkt && !pkt_in && out_last && pkt_len > out_len)
        set_v[S_OVER] = 1'b1;
      set_v[S_FDONE_IN]  = state == ST_FLUSH && flush_in &&
                           in_cnt == 3'd0 && !notice_valid;
      set_v[S_FDONE_OUT] = state == ST_FLUSH && flush_out &&
                           out_cnt == 3'd0 && !notice_valid;
      status <= (status & ~(wr_stat ? w_data[S_W-1:0] : '0)) | set_v;
    end
  end

  // packet state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state     <= ST_IDLE;
      cur_in    <= 1'b0;
      clear_cnt <= 3'd0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (endpoint_clear_request) begin
            state     <= ST_CLEAR;
            clear_cnt <= 3'(CLEAR_CYCLES);
          end else if (token_valid && hs_code == HS_ACK) begin
            state  <= ST_XFER;
            cur_in <= token_in;
          end else if (flush_in || flush_out)
            state <= ST_FLUSH;
        end
        ST_XFER:
          if (pkt_done)
            state <= ST_IDLE;
        ST_FLUSH:
          if (!flush_in && !flush_out)
            state <= ST_IDLE;
        ST_CLEAR: begin
          clear_cnt <= clear_cnt - 3'd1;
          if (clear_cnt == 3'd0)
            state <= ST_IDLE;
        end
      endcase
    end
  end

  // per-packet consumption of the head entry
  wire [LEN_W-1:0] fl_len = pkt_in ? in_len : out_len;
  always_comb begin
    in_use  = 1'b0;
    out_use = 1'b0;
    in_pop  = 1'b0;
    out_pop = 1'b0;
    use_len = pkt_len;
    if (good_pkt && pkt_in && in_cnt != 3'd0) begin
      in_use = 1'b1;
      in_pop = pkt_len >= in_len || in_last;
    end else if (good_pkt && !pkt_in && out_cnt != 3'd0) begin
      out_use = 1'b1;
      out_pop = pkt_len >= out_len || short_pkt || out_last;
    end else if (state == ST_FLUSH && !notice_valid) begin
      in_pop  = flush_in && in_cnt != 3'd0;
      out_pop = flush_out && out_cnt != 3'd0 && !in_pop;
    end
  end

  // completion notices; flush notices carry zero length
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_CLEAR) begin
      notice_valid <= 1'b0;
      notice_in    <= 1'b0;
      notice_len   <= '0;
    end else if (in_use || out_use || in_pop || out_pop) begin
      notice_valid <= 1'b1;
      notice_in    <= in_use || in_pop;
      notice_len   <= (state == ST_FLUSH) ? '0 : min_len(pkt_len, fl_len);
    end else if (notice_ready)
      notice_valid <= 1'b0;
  end

  // prefetch request toward the memory bus
  always_ff @(posedge aclk) begin
    if (!aresetn || state == ST_CLEAR) begin
      fetch_valid <= 1'b0;
      fetch_len   <= '0;
      primed      <= 1'b0;
    end else if (token_valid && token_in && hs_code == HS_ACK) begin
      fetch_valid <= 1'b1;
      primed      <= 1'b0;
      if (in_last || in_cnt == 3'd1)
        fetch_len <= min_len(in_len, in_mtu);
      else
        fetch_len <= min_len(in_len + in_len2, in_mtu);
    end else if (state == ST_IDLE && in_cnt != 3'd0 && !fetch_valid &&
                 !primed) begin
      // one prefetch between in tokens, so a pulse train cannot meet an in token
      fetch_valid <= 1'b1;
      primed      <= 1'b1;
      if (in_last || in_cnt == 3'd1)
        fetch_len <= min_len(in_len, LEN_W'(PREFETCH));
      else
        fetch_len <= min_len(in_len + in_len2, LEN_W'(PREFETCH));
    end else
      fetch_valid <= 1'b0;
  end

  work_queue u_in_q (
    .aclk        (aclk),
    .aresetn     (!q_clear),
    .clear       (1'b0),
    .push        (in_push),
    .push_last   (w_data[P_LAST]),
    .push_len    (w_data[LEN_W-1:0]),
    .pop         (in_pop),
    .consume     (in_use),
    .consume_len (min_len(pkt_len, in_mtu)),
    .head_last   (in_last),
    .head_len    (in_len),
    .second_len  (in_len2),
    .count       (in_cnt)
  );

  work_queue u_out_q (
    .aclk        (aclk),
    .aresetn     (!q_clear),
    .clear       (1'b0),
    .push        (out_push),
    .push_last   (w_data[P_LAST]),
    .push_len    (w_data[LEN_W-1:0]),
    .pop         (out_pop),
    .consume     (out_use),
    .consume_len (use_len),
    .head_last   (out_last),
    .head_len    (out_len),
    .second_len  (out_len2),
    .count       (out_cnt)
  );
endmodule

// [test/usb_host_model.sv]
// host side model: tokens, packet ends and halt clears for one endpoint
module usb_host_model
  import bulk_ep_pkg::*;
(
  input  wire logic        aclk,
  input  wire handshake_e  hs_code,
  output logic             token_valid,
  output logic             token_in,
  output logic             clear_halt,
  output logic             pkt_done,
  output logic             pkt_good,
  output logic             pkt_in,
  output logic [LEN_W-1:0] pkt_len
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    token_valid = 1'h0;
    token_in = 1'h0;
    clear_halt = 1'h0;
    pkt_done = 1'h0;
    pkt_good = 1'h0;
    pkt_in = 1'h0;
    pkt_len = 16'h0;
  end
  // the answer is taken at the same edge that takes the token
  task automatic token(input logic in, output handshake_e c);
    @(posedge aclk);
    token_valid <= 1'h1;
    token_in <= in;
    @(posedge aclk);
    c = hs_code;
    token_valid <= 1'h0;
    token_in <= ~in;
  endtask
  // gap lets the host answer promptly or slowly
  task automatic packet(input logic in, input logic [LEN_W-1:0] len,
                        input logic good, input int gap);
    repeat (gap) @(posedge aclk);
    @(posedge aclk);
    pkt_done <= 1'h1;
    pkt_in <= in;
    pkt_len <= len;
    pkt_good <= good;
    @(posedge aclk);
    pkt_done <= 1'h0;
    pkt_in <= ~in;
    pkt_len <= ~len; // released lines never show stale values
    pkt_good <= ~good;
  endtask
  task automatic halt_clear();
    @(posedge aclk);
    clear_halt <= 1'h1;
    @(posedge aclk);
    clear_halt <= 1'h0;
  endtask
endmodule

// [test/usb_bulk_endpoint_control_asserts.sv]
// port checker for the bulk endpoint control block
module usb_bulk_endpoint_control_asserts
  import bulk_ep_pkg::*;
(
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arready,
  input wire logic             s_axi_rvalid,
  input wire logic             token_valid,
  input wire logic             hs_valid,
  input wire handshake_e       hs_code,
  input wire logic             busy,
  input wire logic             pkt_done,
  input wire logic             notice_valid,
  input wire logic             notice_ready,
  input wire logic [LEN_W-1:0] notice_len,
  input wire logic             fetch_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_HS_ECHO: assert property (hs_valid == token_valid)
    else $error("handshake valid differs from token");
  AST_HS_LEGAL: assert property (hs_valid |-> hs_code inside
    {HS_NAK, HS_ACK, HS_STALL}) else $error("illegal handshake code");
  AST_ACK_BUSY: assert property (hs_valid && hs_code == HS_ACK |=> busy)
    else $error("acknowledged token left endpoint idle");
  AST_BUSY_END: assert property (busy && pkt_done |-> ##[1:4] !busy)
    else $error("endpoint stayed busy after packet end");
  AST_NOTICE_HOLD: assert property
    (notice_valid && !notice_ready |=> notice_valid && $stable(notice_len))
    else $error("notice dropped before taken");
  AST_FETCH_PULSE: assert property (fetch_valid |=> !fetch_valid)
    else $error("fetch request longer than one cycle");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  AST_W_REFUSE: assert property
    (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  cover property (hs_valid && hs_code == HS_STALL);
  cover property (notice_valid && notice_ready);
  cover property (fetch_valid);
endmodule
bind usb_bulk_endpoint_control usb_bulk_endpoint_control_asserts
  usb_bulk_endpoint_control_asserts_i (.*);

// [test/usb_bulk_endpoint_control_tb.sv]
// testbench for the bulk endpoint control block
module usb_bulk_endpoint_control_tb
  import bulk_ep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              aclk, aresetn, token_valid, token_in, clear_halt;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, hs_valid, pkt_done, pkt_good, pkt_in;
  logic              notice_valid, notice_in, notice_ready, fetch_valid;
  logic              busy;
  logic [LEN_W-1:0]  pkt_len, notice_len, fetch_len, flen;
  handshake_e        hs_code, c;
  int                mismatches, checks, fn, f0, k;
  usb_bulk_endpoint_control usb_bulk_endpoint_control_i (.*);
  usb_host_model usb_host_model_i (.*);
  initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
  end
  // fetch pulses last one cycle, so they are caught here, not polled
  always @(posedge aclk) begin
    if (fetch_valid === 1'h1) begin
      fn <= fn + 1;
      flen <= fetch_len;
    end
  end
  task automatic ck(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    ck($sformatf("register %h", a), e, d);
  endtask
  task automatic tok(input logic i, input handshake_e e);
    usb_host_model_i.token(i, c);
    ck("handshake", 32'(e), 32'(c));
  endtask
  task automatic pk(input logic i, input logic [15:0] l, input logic g,
                    input int gap);
    usb_host_model_i.packet(i, l, g, gap);
  endtask
  // valid, direction and length of the next notice in one word
  task automatic nt(input logic i, input logic [15:0] l);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (notice_valid !== 1'h1 && k < 300);
    ck("notice", {14'h0, 1'h1, i, l},
       {14'h0, notice_valid, notice_in, notice_len});
    notice_ready <= 1'h1;
    @(posedge aclk);
    notice_ready <= 1'h0;
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    k = 0;
    do begin
      rd(a);
      k++;
    end while (d[b] !== v && k < 100);
    ck("polled bit", 32'(v), 32'(d[b]));
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    results();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, notice_ready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {mismatches, checks, fn} = 96'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rc(OFF_CTRL, 32'h0);
    rc(OFF_STATUS, 32'h0);
    rc(OFF_IN_MTU, 32'h200);
    rd(8'h40);
    ck("read response", 32'(RESP_SLVERR), 32'(resp));
    wr(8'h44, 32'h1);
    ck("write response", 32'(RESP_SLVERR), 32'(resp));
    wr(OFF_OUT_POST, 32'h200);
    rc(OFF_DEPTH, 32'h10000);
    tok(1'h0, HS_NAK);
    rc(OFF_STATUS, 32'h10);
    wr(OFF_STATUS, 32'h10);
    rc(OFF_STATUS, 32'h0);
    wr(OFF_CTRL, 32'h1);
    tok(1'h0, HS_ACK);
    pk(1'h0, 16'h200, 1'h1, 3);
    nt(1'h0, 16'h200);
    rc(OFF_DEPTH, 32'h0);
    tok(1'h0, HS_NAK);
    rc(OFF_STATUS, 32'h18);
    wr(OFF_STATUS, 32'hff);
    wr(OFF_OUT_POST, 32'h10);
    tok(1'h0, HS_NAK);
    wr(OFF_OUT_POST, 32'h10);
    tok(1'h0, HS_ACK);
    pk(1'h0, 16'h10, 1'h1, 0);
    nt(1'h0, 16'h10);
    wr(OFF_CTRL, 32'h11);
    poll(OFF_CTRL, C_CLEAR, 1'h0);
    rc(OFF_DEPTH, 32'h0);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_OUT_POST, 32'h80000010);
    tok(1'h0, HS_ACK);
    pk(1'h0, 16'h20, 1'h1, 0);
    nt(1'h0, 16'h10);
    rd(OFF_STATUS);
    ck("overflow", 32'h1, 32'(d[S_OVER]));
    wr(OFF_CTRL, 32'h10);
    poll(OFF_CTRL, C_CLEAR, 1'h0);
    wr(OFF_STATUS, 32'hff);
    wr(OFF_COUNT, 32'h400);
    wr(OFF_CTRL, 32'h2);
    wr(OFF_OUT_POST, 32'h200);
    wr(OFF_OUT_POST, 32'h200);
    tok(1'h0, HS_ACK);
    pk(1'h0, 16'h200, 1'h0, 0);
    rc(OFF_COUNT, 32'h400);
    for (int j = 0; j < 2; j++) begin
      tok(1'h0, HS_ACK);
      pk(1'h0, 16'h200, 1'h1, 0);
      nt(1'h0, 16'h200);
      rc(OFF_COUNT, j ? 32'h0 : 32'h200);
    end
    rc(OFF_CTRL, 32'h0);
    rc(OFF_STATUS, 32'h9);
    // a short packet, then a zero-length one, each cut a block short
    for (int j = 0; j < 2; j++) begin
      wr(OFF_STATUS, 32'hff);
      wr(OFF_COUNT, 32'h400);
      wr(OFF_CTRL, 32'h2);
      wr(OFF_OUT_POST, 32'h200);
      tok(1'h0, HS_ACK);
      pk(1'h0, j ? 16'h0 : 16'h10, 1'h1, 0);
      nt(1'h0, j ? 16'h0 : 16'h10);
      rc(OFF_CTRL, 32'h0);
      rc(OFF_STATUS, j ? 32'h2c : 32'hc);
    end
    wr(OFF_CTRL, 32'h10);
    poll(OFF_CTRL, C_CLEAR, 1'h0);
    wr(OFF_STATUS, 32'hff);
    wr(OFF_COUNT, 32'h400);
    wr(OFF_CTRL, 32'h2);
    f0 = fn;
    wr(OFF_IN_POST, 32'h80000020);
    for (k = 0; fn == f0 && k < 100; k++) @(posedge aclk);
    ck("fetch length", 32'h20, 32'(flen));
    tok(1'h1, HS_ACK);
    pk(1'h1, 16'h20, 1'h1, 0);
    nt(1'h1, 16'h20);
    rc(OFF_CTRL, 32'h0);
    rd(OFF_STATUS);
    ck("leftover", 32'h1, 32'(d[S_LEFT]));
    wr(OFF_CTRL, 32'h5);
    tok(1'h0, HS_STALL);
    rc(OFF_CTRL, 32'h1);
    tok(1'h1, HS_STALL);
    usb_host_model_i.halt_clear();
    tok(1'h0, HS_NAK);
    wr(OFF_CTRL, 32'h9);
    tok(1'h0, HS_STALL);
    tok(1'h1, HS_STALL);
    wr(OFF_CTRL, 32'h1);
    tok(1'h1, HS_NAK);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_OUT_POST, 32'h200);
    wr(OFF_OUT_POST, 32'h200);
    wr(OFF_CTRL, 32'h40);
    nt(1'h0, 16'h0);
    nt(1'h0, 16'h0);
    poll(OFF_STATUS, S_FDONE_OUT, 1'h1);
    rc(OFF_DEPTH, 32'h0);
    results();
  end
endmodule
